// ===== tb_uart_bit_rate_change_command.sv
// Self-checking bench for the rate change command handler
`timescale 1ns/1ns
module tb_uart_bit_rate_change_command;
    // Stands in for the host's 1 ms pause; the handler does not time it
    localparam int HOST_GAP = 50;
    localparam logic [31:0] RATES [8] = '{32'h0000_2580, 32'h0001_C200,
        32'h0007_A120, 32'h000F_4240, 32'h0016_E360, 32'h001E_8480,
        32'h003D_0900, 32'h005B_8D80};
    localparam logic [18:0] DIVS [8] = '{19'h0_FFC9, 19'h0_1AFE,
        19'h0_05F5, 19'h0_02F5, 19'h0_01F5, 19'h0_00A3, 19'h4_00A3,
        19'h4_00F5};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, rx_valid = 1'b0, stall = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready;
    logic tx_idle, base_clock_select;
    logic [1:0] bresp, rresp, clock_prescale_select, rs;
    logic [31:0] rdata, rd;
    logic [7:0] tx_data, bit_rate_divisor, modulation_duty_value;
    logic [18:0] exp_div = 19'h0_FFC9;
    wire logic [18:0] div_now = {base_clock_select, clock_prescale_select,
        bit_rate_divisor, modulation_duty_value};
    int fail_count = 0;
    int n_compared = 0;

    ubr_cmd #(.MAX_LEN(16)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_idle(tx_idle),
        .base_clock_select(base_clock_select),
        .clock_prescale_select(clock_prescale_select),
        .bit_rate_divisor(bit_rate_divisor),
        .modulation_duty_value(modulation_duty_value));
    ubr_host_model #(.BYTE_CYC(20)) host_u (.aclk(aclk), .aresetn(aresetn),
        .stall(stall), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_idle(tx_idle));

    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b);
        @(posedge aclk);
        rx_data <= b;
        rx_valid <= 1'b1;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
    endtask

    task automatic send_pkt(input logic [7:0] len, input logic [31:0] rate,
        input logic [7:0] sum_x, input logic [7:0] etx);
        logic [7:0] s;
        logic [7:0] b;
        s = len;
        send_byte(8'h01);
        send_byte(8'h00);
        send_byte(len);
        for (int i = 0; i < len; i++) begin
            b = (i == 0) ? 8'h34 : (i < 5) ? rate[(4 - i) * 8 +: 8] : 8'h00;
            s += b;
            send_byte(b);
        end
        send_byte(-s ^ sum_x);
        send_byte(etx);
    endtask

    // Divisors must hold until the last byte has fully left
    task automatic expect_reply(input logic [7:0] code,
        input logic [7:0] sts, input logic [18:0] nd);
        logic [7:0] e [15];
        logic [7:0] s;
        e = '{8'h81, 8'h00, 8'h0A, code, sts, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
            8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h03};
        s = 8'h00;
        for (int i = 1; i < 13; i++) begin
            s += e[i];
        end
        e[13] = -s;
        while (host_u.got.size() < 15) @(posedge aclk);
        chk_word(div_now, exp_div, "divisor moved early");
        for (int i = 0; i < 15; i++) begin
            chk_word(host_u.got[i], e[i], "reply byte");
        end
        host_u.got.delete();
        while (tx_idle !== 1'b1 || tx_valid !== 1'b0) @(posedge aclk);
        repeat (3) @(posedge aclk);
        chk_word(div_now, nd, "divisor after reply");
        exp_div = nd;
    endtask

    task automatic t_regs();
        axi_rd(ubr_pkg::REG_MAXR, rd, rs);
        chk_word(rd, ubr_pkg::MAXR_RST, "max rate reset");
        axi_rd(ubr_pkg::REG_CTRL, rd, rs);
        chk_word(rd, 32'h0000_0001, "mode reset");
        chk_word(div_now, DIVS[0], "reset divisor");
        axi_rd(5'h10, rd, rs);
        chk_word(rs, ubr_pkg::RESP_SLVERR, "unmapped read");
        axi_wr(ubr_pkg::REG_STAT, 32'hFFFF_FFFF, rs);
        chk_word(rs, ubr_pkg::RESP_SLVERR, "read-only write");
        axi_rd(ubr_pkg::REG_STAT, rd, rs);
        chk_word(rd[18:0], DIVS[0], "status divisor");
    endtask

    task automatic t_rates();
        send_byte(8'h03);
        send_byte(8'h81);
        for (int i = 7; i >= 0; i--) begin
            stall <= i[0];
            send_pkt(8'h05, RATES[i], 8'h00, 8'h03);
            expect_reply(8'h34, 8'h00, DIVS[i]);
            repeat (HOST_GAP) @(posedge aclk);
        end
        stall <= 1'b0;
    endtask

    task automatic t_errors();
        send_pkt(8'h05, RATES[2], 8'h00, 8'h02);
        expect_reply(8'hB4, ubr_pkg::SC_PKT, exp_div);
        send_pkt(8'h05, RATES[2], 8'h5A, 8'h03);
        expect_reply(8'hB4, ubr_pkg::SC_SUM, exp_div);
        send_pkt(8'h05, 32'h0000_3039, 8'h5A, 8'h02);
        expect_reply(8'hB4, ubr_pkg::SC_PKT, exp_div);
        send_pkt(8'h00, RATES[2], 8'h00, 8'h03);
        expect_reply(8'hB4, ubr_pkg::SC_PKT, exp_div);
        send_pkt(8'h06, RATES[2], 8'h00, 8'h03);
        expect_reply(8'hB4, ubr_pkg::SC_PKT, exp_div);
        send_pkt(8'h05, 32'h0000_3039, 8'h00, 8'h03);
        expect_reply(8'hB4, ubr_pkg::SC_PRM, exp_div);
        axi_wr(ubr_pkg::REG_MAXR, RATES[3], rs);
        send_pkt(8'h05, RATES[5], 8'h00, 8'h03);
        expect_reply(8'hB4, ubr_pkg::SC_PRM, exp_div);
        axi_rd(ubr_pkg::REG_LAST, rd, rs);
        chk_word(rd, {16'h0000, ubr_pkg::ERR_CODE, ubr_pkg::SC_PRM},
            "last reply");
        axi_wr(ubr_pkg::REG_MAXR, ubr_pkg::MAXR_RST, rs);
    endtask

    task automatic t_mode();
        axi_wr(ubr_pkg::REG_CTRL, 32'h0, rs);
        send_pkt(8'h05, 32'h0000_3039, 8'h00, 8'h03);
        expect_reply(8'h34, 8'h00, exp_div);
        axi_wr(ubr_pkg::REG_CTRL, 32'h1, rs);
    endtask

    task automatic t_accept();
        axi_wr(ubr_pkg::REG_CTRL, 32'h3, rs);
        send_pkt(8'h05, 32'h0000_3039, 8'h00, 8'h03);
        expect_reply(8'hB4, ubr_pkg::SC_ACC, exp_div);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        exp_div = DIVS[0];
        axi_rd(ubr_pkg::REG_CTRL, rd, rs);
        chk_word(rd, 32'h0000_0001, "pending cleared by reset");
        send_pkt(8'h05, RATES[1], 8'h00, 8'h03);
        expect_reply(8'h34, 8'h00, DIVS[1]);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_rates();
        t_errors();
        t_mode();
        t_accept();
        wrap_up();
    end

    initial begin
        #500000;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up();
    end
endmodule

// ===== ubr_cmd.sv
`timescale 1ns/1ns
// Rate change command packet handler with AXI4-Lite register slave

// Summary of operation
// - Opcode 34h changes only the UART divisor outputs, no other link.
// - Any error leaves the previous UART divisor settings in place.
// - Byte 01h starts a packet; all other bytes are dropped while waiting.
// - Missing terminator 03h gives a packet error reply.
// - Check byte mismatch gives a checksum error reply.
// - Length outside the generic packet format gives a packet error reply.
// - Length must be 00h 05h: opcode plus four rate bytes, else packet error.
// - After any error reply, do nothing and wait for the next packet.
// - Pending encrypted write without reset gives a command acceptance error.
// - Off UART mode, skip parameter checks, reply OK, keep speed.
// - Rate above the advertised maximum gives a parameter error.
// - Rate arrives high byte first; only the eight listed rates are valid.
// - In UART mode send the OK reply at old rate, then switch.
// - OK reply is 81 00 0A 34 00, eight FF bytes, CA, 03.
// - Error reply uses code B4h; highest priority error is reported.
// - Divisor settings follow the table for each supported rate.
module ubr_cmd #(
    parameter int MAX_LEN = 1024
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [4:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [4:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Received bytes from the UART
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    // Reply bytes to the UART transmitter
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_idle,
    // UART divisor settings
    output logic base_clock_select,
    output logic [1:0] clock_prescale_select,
    output logic [7:0] bit_rate_divisor,
    output logic [7:0] modulation_duty_value
);
    if (MAX_LEN < 5 || MAX_LEN > 65535) begin : g_chk
        $error("MAX_LEN must lie between 5 and 65535");
    end

    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_LEN_HI = 8'h02,
        S_LEN_LO = 8'h04,
        S_DATA = 8'h08,
        S_SUM = 8'h10,
        S_ETX = 8'h20,
        S_REPLY = 8'h40,
        S_SWITCH = 8'h80
    } ubr_state_e;

    function automatic logic [3:0] rate_lookup(input logic [31:0] r);
        logic [3:0] found;
        found = 4'h0;
        for (int i = 0; i < ubr_pkg::NUM_RATES; i++) begin
            if (r == ubr_pkg::RATE_TBL[i]) begin
                found = {1'b1, 3'(i)};
            end
        end
        return found;
    endfunction

    function automatic logic [7:0] reply_byte(input logic [3:0] i,
        input logic [7:0] code, input logic [7:0] sts, input logic [7:0] s);
        logic [7:0] b;
        case (i)
            4'h0: b = ubr_pkg::RESP_START;
            4'h1: b = ubr_pkg::RESP_LEN_HI;
            4'h2: b = ubr_pkg::RESP_LEN_LO;
            ubr_pkg::CODE_IDX: b = code;
            ubr_pkg::SC_IDX: b = sts;
            ubr_pkg::SUM_IDX: b = 8'(~s + 8'h01);
            ubr_pkg::LAST_IDX: b = ubr_pkg::END_BYTE;
            default: b = ubr_pkg::FILL_BYTE;
        endcase
        return b;
    endfunction

    ubr_state_e state, next_state;
    logic [7:0] len_hi, sum, cmd, rpl_sts, rpl_code, tx_sum;
    logic [15:0] len, pos;
    logic [31:0] rate, max_rate;
    logic [3:0] idx;
    logic [18:0] div_cfg, new_div;
    logic switch_pend, uart_mode, enc_pend;

    // Packet decode
    wire [15:0] len_in = {len_hi, rx_data};
    wire len_in_ok = len_in != 16'h0000 && len_in <= 16'(MAX_LEN);
    wire fmt_bad = len == 16'h0000 || len > 16'(MAX_LEN);
    wire sum_bad = sum != 8'h00;
    wire etx_bad = rx_data != ubr_pkg::END_BYTE;
    wire etx_seen = state == S_ETX && rx_valid;
    wire rx_take = rx_valid && state != S_REPLY && state != S_SWITCH;
    wire [3:0] hit = rate_lookup(rate);
    wire rate_high = rate > max_rate;
    // Well-formed packets with other opcodes belong to other handlers and are passed over quietly
    wire drop = !etx_bad && !sum_bad && !fmt_bad
        && cmd != ubr_pkg::RATE_OPCODE;
    wire [7:0] err_sts =
        etx_bad ? ubr_pkg::SC_PKT :
        sum_bad ? ubr_pkg::SC_SUM :
        fmt_bad ? ubr_pkg::SC_PKT :
        len != ubr_pkg::CMD_LEN ? ubr_pkg::SC_PKT :
        enc_pend ? ubr_pkg::SC_ACC :
        !uart_mode ? ubr_pkg::SC_OK :
        rate_high ? ubr_pkg::SC_PRM :
        !hit[3] ? ubr_pkg::SC_PRM : ubr_pkg::SC_OK;
    wire go_switch = err_sts == ubr_pkg::SC_OK && uart_mode;

    // Reply transmit
    wire tx_fire = tx_valid && tx_ready;
    wire [3:0] idx_nx = idx + 4'h1;
    wire [7:0] sum_nx = (idx != 4'h0) ? 8'(tx_sum + tx_data) : tx_sum;
    assign tx_valid = state == S_REPLY;

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (rx_valid && rx_data == ubr_pkg::START_BYTE) begin
                    next_state = S_LEN_HI;
                end
            end
            S_LEN_HI: begin
                if (rx_valid) next_state = S_LEN_LO;
            end
            S_LEN_LO: begin
                if (rx_valid) next_state = len_in_ok ? S_DATA : S_SUM;
            end
            S_DATA: begin
                if (rx_valid && pos == 16'(len - 16'h0001)) begin
                    next_state = S_SUM;
                end
            end
            S_SUM: begin
                if (rx_valid) next_state = S_ETX;
            end
            S_ETX: begin
                if (rx_valid) next_state = drop ? S_IDLE : S_REPLY;
            end
            S_REPLY: begin
                if (tx_fire && idx == ubr_pkg::LAST_IDX) begin
                    next_state = switch_pend ? S_SWITCH : S_IDLE;
                end
            end
            S_SWITCH: begin
                if (tx_idle) next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) state <= S_IDLE;
        else state <= next_state;
    end

    // Length bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            len_hi <= 8'h00;
            len <= 16'h0000;
        end else if (rx_valid && state == S_LEN_HI) begin
            len_hi <= rx_data;
        end else if (rx_valid && state == S_LEN_LO) begin
            len <= len_in;
        end
    end

    // Running sum, opcode and rate capture; cleared while waiting
    always_ff @(posedge aclk) begin
        if (!aresetn || state == S_IDLE) begin
            sum <= 8'h00;
            pos <= 16'h0000;
            cmd <= 8'h00;
            rate <= 32'h0000_0000;
        end else if (rx_take) begin
            sum <= 8'(sum + rx_data);
            if (state == S_DATA) begin
                pos <= 16'(pos + 16'h0001);
                if (pos == 16'h0000) begin
                    cmd <= rx_data;
                end else if (pos <= 16'h0004) begin
                    rate <= {rate[23:0], rx_data};
                end
            end
        end
    end

    // Verdict latched at the terminator byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rpl_sts <= ubr_pkg::SC_OK;
            rpl_code <= ubr_pkg::RATE_OPCODE;
            switch_pend <= 1'b0;
            new_div <= ubr_pkg::DIV_TBL[ubr_pkg::RESET_IDX];
        end else if (etx_seen && !drop) begin
            rpl_sts <= err_sts;
            rpl_code <= (err_sts == ubr_pkg::SC_OK) ?
                ubr_pkg::RATE_OPCODE : ubr_pkg::ERR_CODE;
            switch_pend <= go_switch;
            new_div <= ubr_pkg::DIV_TBL[hit[2:0]];
        end
    end

    // Reply bytes are built one ahead so tx_data is always registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx <= 4'h0;
            tx_sum <= 8'h00;
            tx_data <= 8'h00;
        end else if (etx_seen && !drop) begin
            idx <= 4'h0;
            tx_sum <= 8'h00;
            tx_data <= reply_byte(4'h0, 8'h00, 8'h00, 8'h00);
        end else if (tx_fire) begin
            idx <= idx_nx;
            tx_sum <= sum_nx;
            tx_data <= reply_byte(idx_nx, rpl_code, rpl_sts, sum_nx);
        end
    end

    // Only the UART divisors live here; other links never see a change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cfg <= ubr_pkg::DIV_TBL[ubr_pkg::RESET_IDX];
        end else if (state == S_SWITCH && tx_idle) begin
            div_cfg <= new_div;
        end
    end
    assign {base_clock_select, clock_prescale_select, bit_rate_divisor,
        modulation_duty_value} = div_cfg;

    // Register slave; both write channels are taken in the same cycle
    wire wr_go = awvalid && wvalid && !bvalid;
    wire rd_go = arvalid && !rvalid;
    wire wr_ctrl = wr_go && awaddr == ubr_pkg::REG_CTRL;
    wire wr_maxr = wr_go && awaddr == ubr_pkg::REG_MAXR;
    wire [31:0] rd_val =
        araddr == ubr_pkg::REG_CTRL ? {30'h0, enc_pend, uart_mode} :
        araddr == ubr_pkg::REG_MAXR ? max_rate :
        araddr == ubr_pkg::REG_STAT ?
            {11'h0, state != S_IDLE, state == S_SWITCH, div_cfg} :
        araddr == ubr_pkg::REG_LAST ? {16'h0, rpl_code, rpl_sts} :
        32'h0000_0000;
    wire rd_map = araddr == ubr_pkg::REG_CTRL || araddr == ubr_pkg::REG_MAXR
        || araddr == ubr_pkg::REG_STAT || araddr == ubr_pkg::REG_LAST;
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = rd_go;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uart_mode <= ubr_pkg::CTRL_UART_RST;
            enc_pend <= 1'b0;
            max_rate <= ubr_pkg::MAXR_RST;
        end else begin
            if (wr_ctrl && wstrb[0]) begin
                uart_mode <= wdata[ubr_pkg::CTRL_UART];
                // Sticky until device reset, software cannot clear it
                enc_pend <= enc_pend | wdata[ubr_pkg::CTRL_ENC];
            end
            for (int b = 0; b < 4; b++) begin
                if (wr_maxr && wstrb[b]) begin
                    max_rate[8*b +: 8] <= wdata[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= ubr_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= (wr_ctrl || wr_maxr) ?
                ubr_pkg::RESP_OKAY : ubr_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= ubr_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_map ? ubr_pkg::RESP_OKAY : ubr_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Checks
    a_soh_wait_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        state == S_IDLE && rx_valid && rx_data != ubr_pkg::START_BYTE
        |=> state == S_IDLE) else $error("non start byte left idle");
    a_etx_missing_err: assert property (@(posedge aclk) disable iff (!aresetn)
        etx_seen && etx_bad |=> state == S_REPLY
        && rpl_sts == ubr_pkg::SC_PKT) else $error("no packet error");
    a_sum_bad_err: assert property (@(posedge aclk) disable iff (!aresetn)
        etx_seen && !etx_bad && sum_bad |=> rpl_sts == ubr_pkg::SC_SUM
        && rpl_code == ubr_pkg::ERR_CODE) else $error("no sum error");
    a_enc_pend_acc: assert property (@(posedge aclk) disable iff (!aresetn)
        etx_seen && !drop && err_sts == ubr_pkg::SC_ACC |=> !switch_pend
        && tx_data == ubr_pkg::RESP_START) else $error("accept err");
    a_div_only_switch: assert property (@(posedge aclk) disable iff (!aresetn)
        !$stable(div_cfg) |-> $past(state) == S_SWITCH && $past(tx_idle))
        else $error("divisor changed outside switch");
    a_switch_needs_ok: assert property (@(posedge aclk) disable iff (!aresetn)
        state == S_SWITCH |-> uart_mode && rpl_sts == ubr_pkg::SC_OK)
        else $error("switch without uart ok");
    a_reply_sum_ok: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_valid && idx == ubr_pkg::SUM_IDX && rpl_sts == ubr_pkg::SC_OK
        |-> tx_data == 8'hCA) else $error("bad ok check byte");
    a_reply_err_code: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_valid && idx == ubr_pkg::CODE_IDX && rpl_sts != ubr_pkg::SC_OK
        |-> tx_data == ubr_pkg::ERR_CODE) else $error("bad error code");
    a_err_back_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_fire && idx == ubr_pkg::LAST_IDX && !switch_pend
        |=> state == S_IDLE) else $error("no return to wait");
    a_param_err_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        etx_seen && !drop && err_sts == ubr_pkg::SC_PRM
        |=> ##1 !$changed(div_cfg)) else $error("param err changed");
endmodule

// ===== ubr_host_model.sv
// Transmitter side of the programming host serial link
`timescale 1ns/1ns
module ubr_host_model #(
    parameter int BYTE_CYC = 20
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Slow mode refuses every other cycle
    input wire logic stall,
    // Reply bytes from the handler
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic tx_idle
);
    logic [7:0] got [$];
    int cnt = 0;
    logic tick = 1'b0;
    // One byte at a time, like a real serialiser with no holding buffer
    assign tx_ready = (cnt == 0) && !(stall && tick);
    // Idle only after the stop bit has gone, so the switch can wait for it
    assign tx_idle = (cnt == 0);
    always @(posedge aclk) begin
        tick <= ~tick;
        if (!aresetn) begin
            cnt <= 0;
        end else if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            cnt <= BYTE_CYC;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ===== ubr_pkg.sv
// Constants for the UART bit rate change command handler
package ubr_pkg;
    // Packet framing
    localparam logic [7:0] START_BYTE = 8'h01;
    localparam logic [7:0] END_BYTE = 8'h03;
    localparam logic [7:0] RATE_OPCODE = 8'h34;
    localparam logic [15:0] CMD_LEN = 16'h0005;
    localparam logic [15:0] MAX_LEN_DEF = 16'h0400;
    // Reply layout
    localparam logic [7:0] RESP_START = 8'h81;
    localparam logic [7:0] RESP_LEN_HI = 8'h00;
    localparam logic [7:0] RESP_LEN_LO = 8'h0A;
    localparam logic [7:0] ERR_CODE = 8'hB4;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [3:0] CODE_IDX = 4'h3;
    localparam logic [3:0] SC_IDX = 4'h4;
    localparam logic [3:0] SUM_IDX = 4'hD;
    localparam logic [3:0] LAST_IDX = 4'hE;
    // Status codes
    localparam logic [7:0] SC_OK = 8'h00;
    localparam logic [7:0] SC_PKT = 8'hC1;
    localparam logic [7:0] SC_SUM = 8'hC2;
    localparam logic [7:0] SC_ACC = 8'hC3;
    localparam logic [7:0] SC_PRM = 8'hC4;
    // Register offsets and reset values
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_MAXR = 5'h04;
    localparam logic [4:0] REG_STAT = 5'h08;
    localparam logic [4:0] REG_LAST = 5'h0C;
    localparam int CTRL_UART = 0;
    localparam int CTRL_ENC = 1;
    localparam logic CTRL_UART_RST = 1'b1;
    localparam logic [31:0] MAXR_RST = 32'h005B_8D80;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Supported rates and divisor settings {base, prescale, divisor, mod}
    localparam int NUM_RATES = 8;
    localparam logic [2:0] RESET_IDX = 3'h0;
    localparam logic [31:0] RATE_TBL [NUM_RATES] = '{
        32'h0000_2580, 32'h0001_C200, 32'h0007_A120, 32'h000F_4240,
        32'h0016_E360, 32'h001E_8480, 32'h003D_0900, 32'h005B_8D80};
    localparam logic [18:0] DIV_TBL [NUM_RATES] = '{
        19'h0_FFC9, 19'h0_1AFE, 19'h0_05F5, 19'h0_02F5,
        19'h0_01F5, 19'h0_00A3, 19'h4_00A3, 19'h4_00F5};
endpackage
